// ===== design/line_dma_pkg.sv
// Purpose: constants for the two-channel line window dma
// Assumes: 32-bit register port, byte offsets
// Notes:   one word per register, channel q at +ch_span
package line_dma_pkg;
   // register offsets, channel i; channel q adds CH_SPAN, except OFF_MODE which both share
   localparam logic [7:0] OFF_WIN    = 8'h00;
   localparam logic [7:0] OFF_CNT    = 8'h04;
   localparam logic [7:0] OFF_STRIDE = 8'h08;
   localparam logic [7:0] OFF_CADDR  = 8'h0c;
   localparam logic [7:0] OFF_CPOS   = 8'h10;
   localparam logic [7:0] OFF_STAT   = 8'h14;
   localparam logic [7:0] OFF_MODE   = 8'h40;
   localparam logic [7:0] CH_SPAN    = 8'h20;
   localparam logic [7:0] LOC_MASK   = 8'h1f;
   localparam int         CH_SEL_BIT = 5;
   // field positions
   localparam int WIN_LSB    = 3;
   localparam int LINE_LSB   = 16;
   localparam int BPL_LSB    = 1;
   localparam int STRIDE_LSB = 3;
   localparam int STRIDE_MSB = 15;
   localparam int MARK_LSB    = 4;
   localparam int QUEUED_BIT  = 1;
   localparam int RUNNING_BIT = 0;
   // sizes and steps
   localparam int              NCH            = 2;
   localparam int              DATA_W         = 16;
   localparam int              MARK_W         = 4;
   localparam int              FIFO_DEPTH_DEF = 8;
   localparam logic [15:0]     STEP_BYTES     = 16'd2;
   localparam logic [31:0]     RESET_WORD     = 32'h0000_0000;
endpackage

// ===== design/word_fifo.sv
// Purpose: small synchronous word fifo with valid/ready both sides
// Assumes: depth is a power of two
// Notes:   level reports occupancy, ce freezes all state
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   localparam int AW = $clog2(DEPTH),
   localparam int LW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   // occupancy
   output logic      [LW-1:0]    level
);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [LW-1:0] cnt;
   } fifo_s;

   fifo_s            st;
   fifo_s            next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   assign in_ready  = (st.cnt != LW'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data  = mem[st.rp];
   assign level     = st.cnt;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wp = st.wp + 1'b1;
      end
      if (pop) begin
         next_st.rp = st.rp + 1'b1;
      end
      if (push && !pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (pop && !push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////
   // storage, no reset needed
   always_ff @(posedge ref_clk) begin
      if (ce && push) begin
         mem[st.wp] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ===== design/line_window_dma_descriptors.sv
// Purpose: descriptors, status and line walker of a two channel dma
// Assumes: one 16-bit memory access outstanding, ack is one pulse
// Notes:   descriptor set is queued by the line/byte count write
//
// Contract
// [R1] Window start bits 31..3 are writable per channel.
// [R2] Window start bits 2..0 read zero; windows are 8-byte aligned.
// [R3] A full 32-bit write to the window register sets the address.
// [R4] Software never programs a zero line count.
// [R5] Software never programs a zero bytes-per-line upper field.
// [R6] Bytes-per-line bit 0 reads zero; line length is always even.
// [R7] Line stride register holds writable bits 15..3.
// [R8] Line stride bits 2..0 read zero; stride is a multiple of 8.
// [R9] Zero stride repeats the first line line_total times.
// [R10] Status reports the memory address currently being accessed.
// [R11] Status reports current line in 31..16, byte position in 15..0.
// [R12] Receive: watermark holds highest fifo occupancy reached.
// [R13] Transmit: watermark shows fifo emptiness every clock.
// [R14] Queued flag is set while a set waits, clear when writable.
// [R15] Software waits for queued flag zero before new descriptors.
// [R16] Running flag is one while the channel transfers.
// [R17] Software uses the queued flag, not running, to reprogram.
// [R18] Channel q has identical descriptors to channel i.
// [R19] Queue a set while idle-queued, start it when free, step lines.
`timescale 1ns/100ps
`default_nettype none
module line_window_dma_descriptors
   import line_dma_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // clock, reset, enable
   input  wire logic                       ref_clk,
   input  wire logic                       rst_b,
   input  wire logic                       ce,
   // register port
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [31:0]                reg_rdata,
   // memory side
   output logic                            mem_req,
   output logic                            mem_we,
   output logic      [31:0]                mem_addr,
   output logic      [DATA_W-1:0]          mem_wdata,
   input  wire logic                       mem_ack,
   input  wire logic [DATA_W-1:0]          mem_rdata,
   // port receive stream per channel
   input  wire logic [NCH-1:0]             port_rx_valid,
   output logic      [NCH-1:0]             port_rx_ready,
   input  wire logic [NCH-1:0][DATA_W-1:0] port_rx_data,
   // port transmit stream per channel
   output logic      [NCH-1:0]             port_tx_valid,
   input  wire logic [NCH-1:0]             port_tx_ready,
   output logic      [NCH-1:0][DATA_W-1:0] port_tx_data
);
   localparam int LW = $clog2(FIFO_DEPTH + 1);

   typedef struct packed {
      logic [NCH-1:0][28:0] window_addr_upper;
      logic [NCH-1:0][15:0] line_total;
      logic [NCH-1:0][14:0] bytes_per_line_upper;
      logic [NCH-1:0][12:0] line_stride_upper;
      logic [NCH-1:0][15:0] run_lines;
      logic [NCH-1:0][15:0] run_bytes;
      logic [NCH-1:0][31:0] run_stride;
      logic [NCH-1:0][31:0] line_base;
      logic [NCH-1:0][15:0] line_idx;
      logic [NCH-1:0][15:0] byte_pos;
      logic [NCH-1:0][3:0]  fifo_watermark;
      logic [NCH-1:0]       transfer_queued_flag;
      logic [NCH-1:0]       transfer_running_flag;
      logic [NCH-1:0]       tx_mode;
      logic                 busy;
      logic                 owner;
      logic                 we;
      logic [31:0]          addr;
      logic [DATA_W-1:0]    wdata;
      logic [31:0]          rdata;
   } dma_s;

   dma_s                         st;
   dma_s                         next_st;
   logic [NCH-1:0]               fin_valid;
   logic [NCH-1:0]               fin_ready;
   logic [NCH-1:0][DATA_W-1:0]   fin_data;
   logic [NCH-1:0]               fout_valid;
   logic [NCH-1:0]               fout_ready;
   logic [NCH-1:0][DATA_W-1:0]   fout_data;
   logic [NCH-1:0][LW-1:0]       level;
   logic [NCH-1:0][31:0]         cur_addr;
   logic [NCH-1:0]               can_go;
   logic [NCH-1:0]               pop;
   logic                         sel;
   logic [7:0]                   loc;
   logic                         in_ch;

   assign sel       = reg_addr[CH_SEL_BIT];
   assign loc       = reg_addr & LOC_MASK;
   assign in_ch     = (reg_addr < OFF_MODE);
   assign reg_rdata = st.rdata;
   assign mem_req   = st.busy;
   assign mem_we    = st.we;
   assign mem_addr  = st.addr;
   assign mem_wdata = st.wdata;

   ////////////////////////////////////////////////////////////////
   // per channel fifo, direction set by tx_mode
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic ack_here;
      assign ack_here         = st.busy && mem_ack && (st.owner == 1'(g));
      assign cur_addr[g]      = st.line_base[g] + {16'h0000, st.byte_pos[g]}; // [R10]
      assign fin_valid[g]     = st.tx_mode[g] ? (ack_here && !st.we) : port_rx_valid[g];
      assign fin_data[g]      = st.tx_mode[g] ? mem_rdata : port_rx_data[g];
      assign port_rx_ready[g] = !st.tx_mode[g] && fin_ready[g];
      assign port_tx_valid[g] = st.tx_mode[g] && fout_valid[g];
      assign port_tx_data[g]  = fout_data[g];
      assign fout_ready[g]    = st.tx_mode[g] ? port_tx_ready[g] : pop[g];
      assign can_go[g]        = st.transfer_running_flag[g]
                                && (st.tx_mode[g] ? fin_ready[g] : fout_valid[g]);

      word_fifo #(
         .WIDTH (DATA_W),
         .DEPTH (FIFO_DEPTH)
      ) u_fifo (
         .ref_clk   (ref_clk),
         .rst_b     (rst_b),
         .ce        (ce),
         .in_valid  (fin_valid[g]),
         .in_ready  (fin_ready[g]),
         .in_data   (fin_data[g]),
         .out_valid (fout_valid[g]),
         .out_ready (fout_ready[g]),
         .out_data  (fout_data[g]),
         .level     (level[g])
      );
   end

   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_st = st;
      pop     = '0;
      for (int i = 0; i < NCH; i++) begin
         // start a queued set once the channel is free
         if (st.transfer_queued_flag[i] && !st.transfer_running_flag[i]) begin
            next_st.transfer_queued_flag[i]  = 1'b0;                        // [R14] [R19]
            next_st.transfer_running_flag[i] = 1'b1;                        // [R16]
            next_st.run_lines[i]  = st.line_total[i];
            next_st.run_bytes[i]  = {st.bytes_per_line_upper[i], 1'b0};     // [R6]
            next_st.run_stride[i] = {16'h0000, st.line_stride_upper[i], 3'b000}; // [R8]
            next_st.line_base[i]  = {st.window_addr_upper[i], 3'b000};      // [R2]
            next_st.line_idx[i]   = '0;
            next_st.byte_pos[i]   = '0;
            if (!st.tx_mode[i]) begin
               next_st.fifo_watermark[i] = '0;
            end
         end
         // watermark
         if (st.tx_mode[i]) begin
            next_st.fifo_watermark[i] = MARK_W'(LW'(FIFO_DEPTH) - level[i]); // [R13]
         end else if (st.transfer_running_flag[i]
                      && MARK_W'(level[i]) > st.fifo_watermark[i]) begin
            next_st.fifo_watermark[i] = MARK_W'(level[i]);                  // [R12]
         end
      end

      // memory access completes: walk bytes, then lines
      if (st.busy && mem_ack) begin
         next_st.busy = 1'b0;
         if (16'(st.byte_pos[st.owner] + STEP_BYTES) >= st.run_bytes[st.owner]) begin
            next_st.byte_pos[st.owner] = '0;
            if (16'(st.line_idx[st.owner] + 1'b1) >= st.run_lines[st.owner]) begin
               next_st.transfer_running_flag[st.owner] = 1'b0;             // [R16]
            end else begin
               next_st.line_idx[st.owner]  = st.line_idx[st.owner] + 1'b1; // [R11]
               // zero stride keeps the first line's base
               next_st.line_base[st.owner] = st.line_base[st.owner]
                                             + st.run_stride[st.owner];     // [R9] [R19]
            end
         end else begin
            next_st.byte_pos[st.owner] = st.byte_pos[st.owner] + STEP_BYTES; // [R11]
         end
      end else if (!st.busy && (can_go != '0)) begin
         // channel i has priority over channel q
         next_st.busy  = 1'b1;
         next_st.owner = !can_go[0];
         next_st.we    = !st.tx_mode[!can_go[0]];
         next_st.addr  = cur_addr[!can_go[0]];
         next_st.wdata = fout_data[!can_go[0]];
         pop[!can_go[0]] = !st.tx_mode[!can_go[0]];
      end

      // register writes; descriptors only while the selected channel has nothing queued
      if (reg_wr) begin
         if (in_ch && !st.transfer_queued_flag[sel]) begin
            if (loc == OFF_WIN) begin
               next_st.window_addr_upper[sel] = reg_wdata[31:WIN_LSB];     // [R1] [R3] [R18]
            end else if (loc == OFF_CNT) begin
               next_st.line_total[sel]           = reg_wdata[31:LINE_LSB];
               next_st.bytes_per_line_upper[sel] = reg_wdata[LINE_LSB-1:BPL_LSB];
               next_st.transfer_queued_flag[sel] = 1'b1;                   // [R14] [R19]
            end else if (loc == OFF_STRIDE) begin
               next_st.line_stride_upper[sel] = reg_wdata[STRIDE_MSB:STRIDE_LSB]; // [R7]
            end
         end else if (reg_addr == OFF_MODE) begin
            next_st.tx_mode = reg_wdata[NCH-1:0];
         end
      end

      // register reads, answered next cycle
      if (reg_rd) begin
         next_st.rdata = RESET_WORD;
         if (in_ch && loc == OFF_WIN) begin
            next_st.rdata = {st.window_addr_upper[sel], 3'b000};           // [R2]
         end else if (in_ch && loc == OFF_CNT) begin
            next_st.rdata = {st.line_total[sel], st.bytes_per_line_upper[sel], 1'b0}; // [R6]
         end else if (in_ch && loc == OFF_STRIDE) begin
            next_st.rdata = {16'h0000, st.line_stride_upper[sel], 3'b000}; // [R8]
         end else if (in_ch && loc == OFF_CADDR) begin
            next_st.rdata = cur_addr[sel];                                 // [R10]
         end else if (in_ch && loc == OFF_CPOS) begin
            next_st.rdata = {st.line_idx[sel], st.byte_pos[sel]};          // [R11]
         end else if (in_ch && loc == OFF_STAT) begin
            next_st.rdata[MARK_LSB +: MARK_W] = st.fifo_watermark[sel];
            next_st.rdata[QUEUED_BIT]         = st.transfer_queued_flag[sel];
            next_st.rdata[RUNNING_BIT]        = st.transfer_running_flag[sel];
         end else if (reg_addr == OFF_MODE) begin
            next_st.rdata[NCH-1:0] = st.tx_mode;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_win_write_kept: assert property ( // [R1]
      (ce && reg_wr && reg_addr == OFF_WIN && !st.transfer_queued_flag[0])
      |=> st.window_addr_upper[0] == $past(reg_wdata[31:3]))
      else $error("window start write not kept");

   a_win_low_zero: assert property ( // [R2]
      (ce && reg_rd && in_ch && loc == OFF_WIN) |=> reg_rdata[2:0] == 3'h0)
      else $error("window start low bits not zero");

   a_win_read_back: assert property ( // [R3]
      (ce && reg_wr && reg_addr == CH_SPAN && !st.transfer_queued_flag[1])
      ##1 (ce && reg_rd && reg_addr == CH_SPAN && !reg_wr)
      |=> reg_rdata == {$past(reg_wdata[31:3], 2), 3'h0})
      else $error("window start read back differs");

   a_bpl_even: assert property ( // [R6]
      (ce && reg_rd && in_ch && loc == OFF_CNT) |=> !reg_rdata[0])
      else $error("bytes per line read odd");

   a_stride_field: assert property ( // [R8]
      (ce && reg_rd && in_ch && loc == OFF_STRIDE)
      |=> reg_rdata[2:0] == 3'h0 && reg_rdata[31:16] == 16'h0000)
      else $error("line stride fixed bits not zero");

   a_addr_report: assert property ( // [R10]
      (ce && reg_rd && reg_addr == OFF_CADDR) |=> reg_rdata == $past(cur_addr[0]))
      else $error("current address report wrong");

   a_queue_start: assert property ( // [R14]
      (ce && st.transfer_queued_flag[0] && !st.transfer_running_flag[0])
      |=> st.transfer_running_flag[0] && !st.transfer_queued_flag[0]
          && st.line_base[0] == {$past(st.window_addr_upper[0]), 3'h0})
      else $error("queued set did not start");

   a_zero_stride: assert property ( // [R9]
      (ce && st.busy && mem_ack && !st.owner && st.run_stride[0] == 32'h0)
      |=> st.line_base[0] == $past(st.line_base[0]))
      else $error("zero stride moved the line base");

   a_fill_empty: assert property ( // [R13]
      (ce && st.tx_mode[1]) |=> st.fifo_watermark[1] == MARK_W'(LW'(FIFO_DEPTH) - $past(level[1])))
      else $error("transmit watermark wrong");

   a_fill_peak: assert property ( // [R12]
      (ce && !st.tx_mode[0] && st.transfer_running_flag[0] && !st.transfer_queued_flag[0])
      |=> st.fifo_watermark[0] >= MARK_W'($past(level[0])))
      else $error("receive watermark below occupancy");

   a_fill_cleared: assert property ( // [R12]
      (ce && !st.tx_mode[0] && st.transfer_queued_flag[0] && !st.transfer_running_flag[0])
      |=> st.fifo_watermark[0] == 4'h0)
      else $error("receive watermark not cleared at start");

   a_stride_kept: assert property ( // [R7]
      (ce && reg_wr && reg_addr == OFF_STRIDE && !st.transfer_queued_flag[0])
      |=> st.line_stride_upper[0] == $past(reg_wdata[STRIDE_MSB:STRIDE_LSB]))
      else $error("line stride write not kept");

   a_q_win_kept: assert property ( // [R18]
      (ce && reg_wr && reg_addr == CH_SPAN && !st.transfer_queued_flag[1])
      |=> st.window_addr_upper[1] == $past(reg_wdata[31:WIN_LSB]))
      else $error("second channel window write not kept");

   a_cnt_queues: assert property ( // [R14]
      (ce && reg_wr && reg_addr == OFF_CNT && !st.transfer_queued_flag[0])
      |=> st.transfer_queued_flag[0])
      else $error("count write did not queue a set");

   a_refused_write: assert property ( // [R19]
      (ce && reg_wr && reg_addr == OFF_WIN && st.transfer_queued_flag[0])
      |=> $stable(st.window_addr_upper[0]))
      else $error("descriptor changed while a set was queued");

   a_run_ends: assert property ( // [R16]
      (ce && st.busy && mem_ack && !st.owner && st.line_idx[0] == st.run_lines[0] - 16'h0001
       && st.byte_pos[0] == st.run_bytes[0] - STEP_BYTES)
      |=> !st.transfer_running_flag[0])
      else $error("running flag stayed after last access");

   a_pos_step: assert property ( // [R11]
      (ce && st.busy && mem_ack && !st.owner && st.byte_pos[0] != st.run_bytes[0] - STEP_BYTES)
      |=> st.byte_pos[0] == $past(st.byte_pos[0]) + STEP_BYTES)
      else $error("byte position did not step");

   a_line_step: assert property ( // [R19]
      (ce && st.busy && mem_ack && !st.owner && st.byte_pos[0] == st.run_bytes[0] - STEP_BYTES
       && st.line_idx[0] != st.run_lines[0] - 16'h0001)
      |=> st.byte_pos[0] == 16'h0000
          && st.line_base[0] == $past(st.line_base[0]) + $past(st.run_stride[0]))
      else $error("line step wrong");

   a_pos_report: assert property ( // [R11]
      (ce && reg_rd && reg_addr == OFF_CPOS)
      |=> reg_rdata == {$past(st.line_idx[0]), $past(st.byte_pos[0])})
      else $error("current position report wrong");

   a_req_holds: assert property ( // [R10]
      (ce && mem_req && !mem_ack)
      |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
      else $error("memory request changed before acknowledge");

   c_window_done: cover property ($fell(st.transfer_running_flag[0]));
   c_queued_behind: cover property (st.transfer_queued_flag[1] && st.transfer_running_flag[1]);
   c_tx_read: cover property (st.busy && mem_ack && !st.we);
   c_rx_write: cover property (st.busy && mem_ack && st.we);
   c_tx_drain: cover property (port_tx_valid[1] && port_tx_ready[1]);
endmodule
`default_nettype wire

// ===== testbench/line_dma_mem_model.sv
// Purpose: memory partner answering the dma access port
// Assumes: one access outstanding, acknowledge is one pulse
// Notes:   lat sets wait cycles, log_q keeps every finished access
`timescale 1ns/100ps
`default_nettype none
module line_dma_mem_model (
   // clock, reset, answer delay
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  lat,
   // access port
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic             mem_ack,
   output logic      [15:0] mem_rdata
);
   logic [48:0] log_q[$];
   logic [7:0]  wait_n;
   logic [15:0] last;
   ////////////////////////////////////////////////////////////////
   // read data follow the address; between answers the bus shows the inverse of the last word
   assign mem_rdata = mem_ack ? (mem_addr[15:0] ^ 16'h5a5a) : ~last;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_ack <= 1'b0;
         wait_n  <= 8'h00;
         last    <= 16'h0000;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         last    <= mem_rdata;
         log_q.push_back({mem_we, mem_addr, mem_we ? mem_wdata : 16'h0000});
      end else if (mem_req && wait_n >= lat) begin
         mem_ack <= 1'b1;
         wait_n  <= 8'h00;
      end else if (mem_req) begin
         wait_n <= wait_n + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/line_window_dma_descriptors_tb.sv
// Purpose: register and transfer checks of the two channel line dma
// Assumes: memory partner model, channel i receives, channel q transmits
// Notes:   expected accesses are worked out from the descriptors written
`timescale 1ns/100ps
`default_nettype none
module line_window_dma_descriptors_tb import line_dma_pkg::*; ;
   logic                       ref_clk = 1'b0;
   logic                       rst_b, reg_wr, reg_rd, mem_req, mem_we, mem_ack;
   logic [7:0]                 reg_addr, lat;
   logic [31:0]                reg_wdata, reg_rdata, mem_addr;
   logic [DATA_W-1:0]          mem_wdata, mem_rdata;
   logic [NCH-1:0]             rx_valid, rx_ready, tx_valid, tx_ready;
   logic [NCH-1:0][DATA_W-1:0] rx_data, tx_data;
   int                         errors = 0, check_count = 0, cycles = 0;
   logic [7:0]                 offs [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20,
                                             8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h40, 8'h18};
   logic [48:0]                exp_log [11] = '{49'h1_1000_0000_1100, 49'h1_1000_0002_1101,
      49'h1_1000_0100_1102, 49'h1_1000_0102_1103, 49'h1_2000_0000_2200, 49'h1_2000_0000_2201,
      49'h1_2000_0000_2202, 49'h0_4000_0000_0000, 49'h0_4000_0002_0000, 49'h0_4000_0004_0000,
      49'h0_4000_0006_0000};
   ////////////////////////////////////////////////////////////////
   always #25 ref_clk = ~ref_clk;
   line_window_dma_descriptors #(.FIFO_DEPTH(8)) DUT (
      .ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .port_rx_valid(rx_valid), .port_rx_ready(rx_ready), .port_rx_data(rx_data),
      .port_tx_valid(tx_valid), .port_tx_ready(tx_ready), .port_tx_data(tx_data));
   line_dma_mem_model mem (
      .ref_clk(ref_clk), .rst_b(rst_b), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [48:0] exp, input logic [48:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk($sformatf("register %h", a), {17'h0, exp}, {17'h0, reg_rdata});
   endtask
   // write then read back with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk($sformatf("register %h", a), {17'h0, exp}, {17'h0, reg_rdata});
   endtask
   // one word into the receive stream of a channel, held until taken
   task automatic push(input int ch, input logic [15:0] d);
      @(posedge ref_clk);
      rx_valid[ch] <= 1'b1;
      rx_data[ch]  <= d;
      for (int i = 0; i < 200; i++) begin
         @(negedge ref_clk);
         if (rx_ready[ch] === 1'b1) break;
      end
      @(posedge ref_clk);
      rx_valid[ch] <= 1'b0;
   endtask
   task automatic pop(input logic [15:0] exp);
      @(posedge ref_clk);
      tx_ready[1] <= 1'b1;
      for (int i = 0; i < 200; i++) begin
         @(negedge ref_clk);
         if (tx_valid[1] === 1'b1) break;
      end
      chk("transmit word", {33'h0, exp}, {33'h0, tx_data[1]});
      @(posedge ref_clk);
      tx_ready[1] <= 1'b0;
   endtask
   task automatic wait_log(input int n);
      for (int i = 0; i < 400 && mem.log_q.size() < n; i++) @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up;
      end
   end
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      lat = 8'h00;
      rx_valid = '0;
      rx_data = '0;
      tx_ready = '0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      // reset values, unmapped place included
      foreach (offs[i]) rd(offs[i], 32'h0);
      wr(8'h0c, 32'hffff_ffff);
      wr(8'h18, 32'hffff_ffff);
      rd(8'h0c, 32'h0);
      rd(8'h18, 32'h0);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h00, 32'hffff_fff8);
      wr(8'h08, 32'hffff_ffff);
      rd(8'h08, 32'h0000_fff8);
      wr(8'h00, 32'h1000_0007);
      wr(8'h08, 32'h0000_0107);
      wr(8'h04, 32'h0002_0005);
      rd(8'h04, 32'h0002_0004);
      rd(8'h14, 32'h0000_0001);
      // second set behind the running one, repeating one line
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h2000_0000);
      wr(8'h04, 32'h0003_0002);
      rd(8'h14, 32'h0000_0003);
      wr(8'h00, 32'h3000_0000);
      rd(8'h00, 32'h2000_0000);
      for (int k = 0; k < 3; k++) push(0, 16'h1100 + 16'(k));
      wait_log(3);
      rd(8'h0c, 32'h1000_0102);
      rd(8'h10, 32'h0001_0002);
      push(0, 16'h1103);
      wait_log(4);
      lat <= 8'd40;
      for (int k = 0; k < 3; k++) push(0, 16'h2200 + 16'(k));
      wait_log(7);
      rd(8'h14, 32'h0000_0020);
      // channel q transmits with a stalled port
      lat <= 8'd3;
      wr(OFF_MODE, 32'h0000_0002);
      wr_rd(8'h20, 32'h4000_0005, 32'h4000_0000);
      wr(8'h28, 32'h0000_0008);
      wr(8'h24, 32'h0001_0009);
      rd(8'h24, 32'h0001_0008);
      wait_log(11);
      rd(8'h34, 32'h0000_0040);
      foreach (exp_log[i]) chk("memory access", exp_log[i], mem.log_q[i]);
      for (int k = 0; k < 4; k++) pop(16'h5a5a ^ 16'(2 * k));
      rd(8'h34, 32'h0000_0080);
      wrap_up;
   end
endmodule
`default_nettype wire
